// [hdl/ddrs_consts.vh]
// register offsets, field positions, reset values and timing counts
`ifndef DDRS_CONSTS_VH
`define DDRS_CONSTS_VH
// ==========================================================
// register select codes
`define DDRS_SEL_ERROR      5'h02
`define DDRS_SEL_MAINT      5'h03
`define DDRS_SEL_ATTN       5'h04
`define DDRS_SEL_SECTRK     5'h05
`define DDRS_SEL_ROTPOS     5'h07
`define DDRS_SEL_CLASS      5'h06
`define DDRS_SEL_SERIAL     5'h0C
`define DDRS_SEL_OFFSET     5'h0D
`define DDRS_SEL_CONTROL    5'h00
`define DDRS_SEL_STATUS     5'h01
// ==========================================================
// field positions
`define DDRS_ERR_NOPROG     13
`define DDRS_ERR_UNSAFE     14
`define DDRS_ERR_RDCHK      15
`define DDRS_ERR_BADADDR    10
`define DDRS_MNT_DIAG       0
`define DDRS_MNT_WRAPCLK    1
`define DDRS_MNT_WRAPDATA   2
`define DDRS_MNT_WRAPEN     3
`define DDRS_MNT_WRAPOUT    4
`define DDRS_OFS_CORRINH    11
`define DDRS_CTL_GO         0
`define DDRS_CTL_FUNC_CLR   5'h04
`define DDRS_STS_READY      7
`define DDRS_CLS_DUAL       11
`define DDRS_CLS_MOVHEAD    13
// ==========================================================
// reset values and limits
`define DDRS_RST_WORD       16'h0000
`define DDRS_MAX_SECT16     5'h15
`define DDRS_MAX_SECT18     5'h13
`define DDRS_MAX_TRACK      5'h12
`define DDRS_IDLE_INDEXES   2'h3
`endif

// [hdl/ddrs_wrap_shifter.v]
// diagnostic wrap-around shift register
`timescale 1ns/10ps
module ddrs_wrap_shifter (
  clk,
  reset,
  enable,
  loadWord,
  loadData,
  shiftPulse,
  serialIn,
  wordOut,
  serialOut
);
  input         clk;
  input         reset;
  input         enable;
  input         loadWord;
  input  [15:0] loadData;
  input         shiftPulse;
  input         serialIn;
  output [15:0] wordOut;
  output        serialOut;
  reg    [15:0] shift_reg;
  reg    [15:0] shift_next;
  // ==========================================================
  // load or shift one bit per software clock pulse
  always @* begin
    shift_next = shift_reg;
    if (loadWord) begin
      shift_next = loadData;
    end else if (enable && shiftPulse) begin
      shift_next = {serialIn, shift_reg[15:1]};
    end
  end
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      shift_reg <= 16'h0000;
    end else begin
      shift_reg <= shift_next;
    end
  end
  assign wordOut   = shift_reg;
  assign serialOut = shift_reg[0];
endmodule // ddrs_wrap_shifter

// [hdl/ddrs_register_set.v]
// drive register set: error flags, maintenance, attention, addressing
`timescale 1ns/10ps
// How it works
// R1 - three index pulses with no activity after a command set no-progress
// R2 - no-progress clears go bit and sets ready
// R3 - unsafe flag, error bit 14, set by drive condition and held; survives clear while condition lasts
// R4 - read-check flag, bit 15, set on code error after check bytes
// R5 - correction inhibit clear: start correction, keep read-check set
// R6 - correction inhibit set: skip correction despite code error
// R7 - next sector continues only if continue line high at block end fall
// R8 - drive clear or bus clear resets all error flags
// R9 - transfer-error line raised only during end-of-block pulse after correction done
// R10 - maintenance register read/write except wrap-out bit 4; diag bit enables diagnostics
// R11 - wrap-around shifting by software clock only in diagnostic mode
// R12 - read of register 04 drives attention bit onto unit's line
// R13 - writing one clears attention for that controller only
// R14 - power-up raises attention to both controllers
// R15 - persistent error forces neutral; attention waits for a request
// R16 - sector/track register; invalid address beyond 22 sectors (20 with format18), 19 tracks
// R17 - six-bit subsector count clears at sector rise; top bits give quarter
// R18 - sector count resets at index rise; wraps at 21 or 19
// R19 - sector found by exclusive-or of count and desired sector
// R20 - class register: type bits 0-8, dual bit 11, moving head 13
// R21 - serial register is jumper-set, read only
// R22 - offset register bits 0-7 hold head offset
// R23 - writes to read-only registers are silently dropped
`include "ddrs_consts.vh"
module ddrs_register_set (
  clk,
  reset,
  regSelect,
  regWrite,
  regRead,
  portB,
  writeData,
  readData,
  attnLines,
  busClear,
  unitNumber,
  typeJumpers,
  dualPort,
  serialJumpers,
  indexPulse,
  sectorPulse,
  subsectorTick,
  format18,
  activity,
  unsafeCondition,
  powerUp,
  persistentError,
  otherRequested,
  driveRequest,
  codeError,
  checkDone,
  correctionDone,
  endOfBlockPulse,
  transferContinue,
  sectorMatch,
  transferError,
  goBit,
  readyFlag,
  neutralState,
  correctionActive,
  continueNext,
  attnA,
  attnB
);
  input         clk;
  input         reset;
  input  [4:0]  regSelect;
  input         regWrite;
  input         regRead;
  input         portB;
  input  [15:0] writeData;
  output [15:0] readData;
  output [7:0]  attnLines;
  input         busClear;
  input  [2:0]  unitNumber;
  input  [8:0]  typeJumpers;
  input         dualPort;
  input  [15:0] serialJumpers;
  input         indexPulse;
  input         sectorPulse;
  input         subsectorTick;
  input         format18;
  input         activity;
  input         unsafeCondition;
  input         powerUp;
  input         persistentError;
  input         otherRequested;
  input         driveRequest;
  input         codeError;
  input         checkDone;
  input         correctionDone;
  input         endOfBlockPulse;
  input         transferContinue;
  output        sectorMatch;
  output        transferError;
  output        goBit;
  output        readyFlag;
  output        neutralState;
  output        correctionActive;
  output        continueNext;
  output        attnA;
  output        attnB;

  reg    [15:0] readData;
  reg    [15:0] maint_reg;
  reg    [15:0] sectTrk_reg;
  reg    [15:0] offset_reg;
  reg           go_reg;
  reg           ready_reg;
  reg    [1:0]  idleIdx_reg;
  reg           noProg_reg;
  reg           unsafe_reg;
  reg           rdChk_reg;
  reg           badAddr_reg;
  reg           corr_reg;
  reg           xferErr_reg;
  reg           cont_reg;
  reg           attnA_reg;
  reg           attnB_reg;
  reg           neutral_reg;
  reg           idxDly_reg;
  reg           secDly_reg;
  reg           eobDly_reg;
  reg           pwrDly_reg;
  reg    [5:0]  subsec_reg;
  reg    [4:0]  secCnt_reg;
  reg    [7:0]  attnOut;

  wire          idxRise = indexPulse & ~idxDly_reg;
  wire          secRise = sectorPulse & ~secDly_reg;
  wire          eobFall = ~endOfBlockPulse & eobDly_reg;
  wire          pwrRise = powerUp & ~pwrDly_reg;
  wire          wrEn    = regWrite;
  wire          clrCmd  = (wrEn && regSelect == `DDRS_SEL_CONTROL &&
                           writeData[5:1] == `DDRS_CTL_FUNC_CLR);
  wire          clrAll  = clrCmd | busClear;
  wire          diagOn  = maint_reg[`DDRS_MNT_DIAG];
  wire          corrInh = offset_reg[`DDRS_OFS_CORRINH];
  wire [4:0]    maxSect = format18 ? `DDRS_MAX_SECT18 : `DDRS_MAX_SECT16;
  wire          addrBad = (sectTrk_reg[4:0] > maxSect) ||
                          (sectTrk_reg[12:8] > `DDRS_MAX_TRACK);
  wire [4:0]    xorCmp  = secCnt_reg ^ sectTrk_reg[4:0];
  wire          rdChkEv = codeError & checkDone;
  wire          noProgEv = go_reg & idxRise & ~activity &
                           (idleIdx_reg == `DDRS_IDLE_INDEXES - 2'h1);
  wire [15:0]   wrapWord;
  wire          wrapBit;
  wire          thisPort = ~portB;

  // ==========================================================
  // wrap-around shifter, live only under diagnostic mode
  ddrs_wrap_shifter u_wrap (
    .clk        (clk),
    .reset      (reset),
    .enable     (diagOn & maint_reg[`DDRS_MNT_WRAPEN]), // R11
    .loadWord   (diagOn & wrEn & regSelect == `DDRS_SEL_OFFSET),
    .loadData   (writeData),
    .shiftPulse (wrEn & regSelect == `DDRS_SEL_MAINT &
                 writeData[`DDRS_MNT_WRAPCLK] &
                 ~maint_reg[`DDRS_MNT_WRAPCLK]),
    .serialIn   (maint_reg[`DDRS_MNT_WRAPDATA]),
    .wordOut    (wrapWord),
    .serialOut  (wrapBit)
  );

  // ==========================================================
  // edge detectors and rotational counters
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      idxDly_reg <= 1'b0;
      secDly_reg <= 1'b0;
      eobDly_reg <= 1'b0;
      pwrDly_reg <= 1'b0;
      subsec_reg <= 6'h00;
      secCnt_reg <= 5'h00;
    end else begin
      idxDly_reg <= indexPulse;
      secDly_reg <= sectorPulse;
      eobDly_reg <= endOfBlockPulse;
      pwrDly_reg <= powerUp;
      if (secRise) begin
        subsec_reg <= 6'h00; // R17
      end else if (subsectorTick) begin
        subsec_reg <= subsec_reg + 6'h01;
      end
      if (idxRise) begin
        secCnt_reg <= 5'h00; // R18
      end else if (secRise) begin
        // wrap keeps a missed index from running past the format
        secCnt_reg <= (secCnt_reg >= maxSect) ? 5'h00 :
                      secCnt_reg + 5'h01; // R18
      end
    end
  end

  // ==========================================================
  // command state and error flags
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      go_reg      <= 1'b0;
      ready_reg   <= 1'b1;
      idleIdx_reg <= 2'h0;
      noProg_reg  <= 1'b0;
      unsafe_reg  <= 1'b0;
      rdChk_reg   <= 1'b0;
      badAddr_reg <= 1'b0;
      corr_reg    <= 1'b0;
      xferErr_reg <= 1'b0;
      cont_reg    <= 1'b0;
    end else begin
      if (noProgEv) begin
        go_reg    <= 1'b0; // R2
        ready_reg <= 1'b1; // R2
      end else if (wrEn && regSelect == `DDRS_SEL_CONTROL &&
                   writeData[`DDRS_CTL_GO] && !clrCmd) begin
        go_reg    <= 1'b1;
        ready_reg <= 1'b0;
      end else if (go_reg && activity && eobFall && !transferContinue) begin
        go_reg    <= 1'b0;
        ready_reg <= 1'b1;
      end
      if (!go_reg || activity) begin
        idleIdx_reg <= 2'h0;
      end else if (idxRise) begin
        idleIdx_reg <= idleIdx_reg + 2'h1; // R1
      end
      // set wins over clear on every flag
      noProg_reg  <= noProgEv | (noProg_reg & ~clrAll); // R1 R8
      unsafe_reg  <= unsafeCondition | (unsafe_reg & ~clrAll); // R3 R8
      rdChk_reg   <= rdChkEv | (rdChk_reg & ~clrAll); // R4 R5 R8
      badAddr_reg <= (go_reg & addrBad) | (badAddr_reg & ~clrAll); // R16
      if (rdChkEv && !corrInh) begin
        corr_reg <= 1'b1; // R5
      end else if (correctionDone || corrInh) begin
        corr_reg <= 1'b0; // R6
      end
      if (corr_reg && correctionDone) begin
        xferErr_reg <= 1'b1; // R9
      end else if (eobFall) begin
        xferErr_reg <= 1'b0; // R9
      end
      if (eobFall) begin
        cont_reg <= transferContinue; // R7
      end
    end
  end

  // ==========================================================
  // maintenance, sector/track and offset registers
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      maint_reg   <= `DDRS_RST_WORD;
      sectTrk_reg <= `DDRS_RST_WORD;
      offset_reg  <= `DDRS_RST_WORD;
    end else begin
      if (wrEn && regSelect == `DDRS_SEL_MAINT) begin
        maint_reg <= writeData; // R10
      end else begin
        maint_reg[`DDRS_MNT_WRAPOUT] <= wrapBit & diagOn; // R11
      end
      if (wrEn && regSelect == `DDRS_SEL_SECTRK && !go_reg) begin
        sectTrk_reg <= writeData; // R16
      end
      if (wrEn && regSelect == `DDRS_SEL_OFFSET && !go_reg) begin
        offset_reg <= writeData; // R22
      end
    end
  end

  // ==========================================================
  // attention flags, one per controller
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      attnA_reg   <= 1'b0;
      attnB_reg   <= 1'b0;
      neutral_reg <= 1'b0;
    end else begin
      if (persistentError) begin
        neutral_reg <= 1'b1; // R15
      end else if (driveRequest) begin
        neutral_reg <= 1'b0;
      end
      if (pwrRise ||
          (neutral_reg && (driveRequest || otherRequested))) begin
        attnA_reg <= 1'b1; // R14 R15
        attnB_reg <= 1'b1; // R14
      end else if (wrEn && regSelect == `DDRS_SEL_ATTN &&
                   writeData[unitNumber]) begin
        // a write only reaches the writing controller's flag
        if (thisPort) begin
          attnA_reg <= 1'b0; // R13
        end else begin
          attnB_reg <= 1'b0; // R13
        end
      end
    end
  end

  // ==========================================================
  // read multiplexer; writes to read-only selects just fall away
  always @* begin
    readData = 16'h0000;
    attnOut  = 8'h00;
    if (regRead && regSelect == `DDRS_SEL_ATTN) begin
      attnOut[unitNumber] = thisPort ? attnA_reg : attnB_reg; // R12
    end
    if (regSelect == `DDRS_SEL_ERROR) begin
      readData[`DDRS_ERR_NOPROG]  = noProg_reg;
      readData[`DDRS_ERR_UNSAFE]  = unsafe_reg;
      readData[`DDRS_ERR_RDCHK]   = rdChk_reg;
      readData[`DDRS_ERR_BADADDR] = badAddr_reg;
    end else if (regSelect == `DDRS_SEL_STATUS) begin
      readData[`DDRS_STS_READY] = ready_reg;
    end else if (regSelect == `DDRS_SEL_CONTROL) begin
      readData[`DDRS_CTL_GO] = go_reg;
    end else if (regSelect == `DDRS_SEL_MAINT) begin
      readData = maint_reg; // R10
    end else if (regSelect == `DDRS_SEL_ATTN) begin
      readData[7:0] = attnOut;
    end else if (regSelect == `DDRS_SEL_SECTRK) begin
      readData = sectTrk_reg;
    end else if (regSelect == `DDRS_SEL_ROTPOS) begin
      readData = {5'h00, secCnt_reg, subsec_reg}; // R17 R18
    end else if (regSelect == `DDRS_SEL_CLASS) begin
      readData[8:0]              = typeJumpers; // R20
      readData[`DDRS_CLS_DUAL]    = dualPort; // R20
      readData[`DDRS_CLS_MOVHEAD] = 1'b1; // R20
    end else if (regSelect == `DDRS_SEL_SERIAL) begin
      readData = serialJumpers; // R21 R23
    end else if (regSelect == `DDRS_SEL_OFFSET) begin
      readData = diagOn ? wrapWord : offset_reg; // R22
    end
  end

  assign attnLines        = attnOut;
  assign sectorMatch      = (xorCmp == 5'h00); // R19
  assign transferError    = xferErr_reg & endOfBlockPulse; // R9
  assign goBit            = go_reg;
  assign readyFlag        = ready_reg;
  assign neutralState     = neutral_reg;
  assign correctionActive = corr_reg;
  assign continueNext     = cont_reg; // R7
  assign attnA            = attnA_reg;
  assign attnB            = attnB_reg;
endmodule // ddrs_register_set

// [verification/ddrs_ctl_model.sv]
// controller-side model driving the transfer-continue line
`timescale 1ns/10ps
module ddrs_ctl_model (
  clk,
  reset,
  endOfBlockPulse,
  wantRun,
  transferContinue
);
  input  clk;
  input  reset;
  input  endOfBlockPulse;
  input  wantRun;
  output transferContinue;
  reg    contReg;
  // ====================
  // continue line
  // changes only between blocks, never under the pulse
  always @(posedge clk or posedge reset) begin
    if (reset)
      contReg <= 1'h0;
    else if (!endOfBlockPulse)
      contReg <= wantRun;
  end
  assign transferContinue = contReg;
endmodule // ddrs_ctl_model

// [verification/ddrs_register_set_chk.sv]
// assertion checker for the drive register set
`timescale 1ns/10ps
module ddrs_register_set_chk (
  clk,
  reset,
  regSelect,
  regRead,
  readData,
  attnLines,
  unitNumber,
  typeJumpers,
  dualPort,
  serialJumpers,
  powerUp,
  endOfBlockPulse,
  transferError,
  goBit,
  readyFlag,
  attnA,
  attnB
);
  input        clk, reset, regRead, dualPort, powerUp;
  input        endOfBlockPulse, transferError, goBit, readyFlag;
  input        attnA, attnB;
  input [4:0]  regSelect;
  input [15:0] readData, serialJumpers;
  input [7:0]  attnLines;
  input [2:0]  unitNumber;
  input [8:0]  typeJumpers;
  wire         atRd = regRead && regSelect == 5'h04;
  // ====================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence powerRise; $rose(powerUp); endsequence
  sequence bothAttn; attnA && attnB; endsequence
  chk_xfer_err_eob: assert property (transferError |-> endOfBlockPulse)
    else $error("transfer error outside block end");
  chk_xfer_err_hold: assert property (transferError |=>
    transferError || !endOfBlockPulse)
    else $error("transfer error dropped inside block end");
  chk_go_not_ready: assert property (goBit |-> !readyFlag)
    else $error("ready while command runs");
  chk_attn_quiet: assert property (!atRd |-> attnLines == 8'h00)
    else $error("attention lines driven without select");
  chk_attn_own_bit: assert property (atRd |->
    (attnLines & ~(8'h01 << unitNumber)) == 8'h00)
    else $error("attention on foreign line");
  chk_class_value: assert property (regSelect == 5'h06 |-> readData ==
    {2'h0, 1'h1, 1'h0, dualPort, 2'h0, typeJumpers})
    else $error("class register wrong");
  chk_serial_value: assert property (regSelect == 5'h0C |->
    readData == serialJumpers)
    else $error("serial register wrong");
  chk_power_attn: assert property (powerRise |-> ##[1:3] bothAttn)
    else $error("power-up attention missing");
  chk_sector_range: assert property (regSelect == 5'h07 |->
    readData[10:6] <= 5'h15 && readData[15:11] == 5'h00)
    else $error("sector count out of range");
endmodule // ddrs_register_set_chk

bind ddrs_register_set ddrs_register_set_chk ddrs_register_set_chk_inst (
  .clk, .reset, .regSelect, .regRead, .readData, .attnLines, .unitNumber,
  .typeJumpers, .dualPort, .serialJumpers, .powerUp, .endOfBlockPulse,
  .transferError, .goBit, .readyFlag, .attnA, .attnB);

// [verification/testbench.sv]
// self-checking bench for the drive register set
`timescale 1ns/10ps
`include "ddrs_consts.vh"
module testbench;
  reg         clk, reset, regWrite, regRead, portB, busClear;
  reg  [4:0]  regSelect;
  reg  [15:0] writeData, rv;
  reg  [7:0]  av;
  reg         indexPulse, sectorPulse, subsectorTick, activity, format18;
  reg         unsafeCondition, powerUp, persistentError, codeError;
  reg         checkDone, correctionDone, endOfBlockPulse, wantRun;
  reg         otherRequested, driveRequest;
  wire [15:0] readData;
  wire [7:0]  attnLines;
  wire        sectorMatch, transferError, goBit, readyFlag, neutralState;
  wire        correctionActive, continueNext, attnA, attnB, transferContinue;
  integer     n_errors, tests_run, i;
  // ====================
  // design and controller model
  ddrs_register_set ddrs_register_set_inst (
    .clk, .reset, .regSelect, .regWrite, .regRead, .portB, .writeData,
    .readData, .attnLines, .busClear, .unitNumber(3'h5),
    .typeJumpers(9'h0A5), .dualPort(1'h1), .serialJumpers(16'h1234),
    .indexPulse, .sectorPulse, .subsectorTick, .format18, .activity,
    .unsafeCondition, .powerUp, .persistentError, .otherRequested,
    .driveRequest, .codeError, .checkDone, .correctionDone,
    .endOfBlockPulse, .transferContinue, .sectorMatch, .transferError,
    .goBit, .readyFlag, .neutralState, .correctionActive, .continueNext,
    .attnA, .attnB);
  ddrs_ctl_model ddrs_ctl_model_inst (
    .clk, .reset, .endOfBlockPulse, .wantRun, .transferContinue);
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  // ====================
  // helpers
  task cmp(input [15:0] got, input [15:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task cmp1(input got, input exp);
    cmp({15'h0000, got}, {15'h0000, exp});
  endtask
  task step(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task wr(input [4:0] s, input [15:0] d);
    begin
      @(posedge clk);
      regSelect <= s;
      writeData <= d;
      regWrite  <= 1'h1;
      @(posedge clk);
      regWrite  <= 1'h0;
    end
  endtask
  task rdc(input [4:0] s, input [15:0] exp);
    begin
      @(posedge clk);
      regSelect <= s;
      regRead   <= 1'h1;
      #1 rv = readData;
      av = attnLines;
      @(posedge clk);
      regRead   <= 1'h0;
      cmp(rv, exp);
    end
  endtask
  task pulseIndex;
    begin
      @(posedge clk);
      indexPulse <= 1'h1;
      step(2);
      indexPulse <= 1'h0;
      step(2);
    end
  endtask
  task pulseSector;
    begin
      @(posedge clk);
      sectorPulse <= 1'h1;
      step(2);
      sectorPulse <= 1'h0;
      step(2);
    end
  endtask
  task pulseCheck;
    begin
      @(posedge clk);
      checkDone <= 1'h1;
      @(posedge clk);
      checkDone <= 1'h0;
      step(2);
    end
  endtask
  task give_verdict;
    begin
      if (n_errors == 0 && tests_run > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  // ====================
  // scenarios
  task t_regs;
    begin
      rdc(`DDRS_SEL_MAINT, 16'h0000);
      wr(`DDRS_SEL_MAINT, 16'h5A00);
      rdc(`DDRS_SEL_MAINT, 16'h5A00);
      wr(`DDRS_SEL_MAINT, 16'h0000);
      wr(`DDRS_SEL_CLASS, 16'hFFFF);
      rdc(`DDRS_SEL_CLASS, 16'h28A5);
      wr(`DDRS_SEL_SERIAL, 16'hFFFF);
      rdc(`DDRS_SEL_SERIAL, 16'h1234);
      rdc(`DDRS_SEL_ERROR, 16'h0000);
      wr(`DDRS_SEL_OFFSET, 16'h00C3);
      rdc(`DDRS_SEL_OFFSET, 16'h00C3);
    end
  endtask
  task t_noprog;
    begin
      wr(`DDRS_SEL_SECTRK, 16'h0017);
      wr(`DDRS_SEL_CONTROL, 16'h0001);
      step(1);
      cmp1(goBit, 1'h1);
      rdc(`DDRS_SEL_ERROR, 16'h0400);
      for (i = 0; i < 3; i = i + 1)
        pulseIndex;
      // bounded wait so a stuck command cannot hang the run
      i = 0;
      while (goBit !== 1'h0 && i < 20) begin
        @(posedge clk);
        i = i + 1;
      end
      if (i == 20) begin
        n_errors = n_errors + 1;
        give_verdict;
      end
      cmp1(readyFlag, 1'h1);
      rdc(`DDRS_SEL_ERROR, 16'h2400);
      wr(`DDRS_SEL_CONTROL, 16'h0008);
      rdc(`DDRS_SEL_ERROR, 16'h0000);
    end
  endtask
  task t_rdchk;
    begin
      wr(`DDRS_SEL_OFFSET, 16'h0000);
      wantRun   <= 1'h1;
      codeError <= 1'h1;
      pulseCheck;
      cmp1(correctionActive, 1'h1);
      rdc(`DDRS_SEL_ERROR, 16'h8000);
      correctionDone <= 1'h1;
      step(1);
      correctionDone <= 1'h0;
      rdc(`DDRS_SEL_ERROR, 16'h8000);
      endOfBlockPulse <= 1'h1;
      step(2);
      cmp1(transferError, 1'h1);
      endOfBlockPulse <= 1'h0;
      step(3);
      cmp1(continueNext, 1'h1);
      wantRun <= 1'h0;
      step(2);
      endOfBlockPulse <= 1'h1;
      step(2);
      endOfBlockPulse <= 1'h0;
      step(3);
      cmp1(continueNext, 1'h0);
      busClear <= 1'h1;
      step(1);
      busClear <= 1'h0;
      rdc(`DDRS_SEL_ERROR, 16'h0000);
      wr(`DDRS_SEL_OFFSET, 16'h0800);
      pulseCheck;
      cmp1(correctionActive, 1'h0);
      rdc(`DDRS_SEL_ERROR, 16'h8000);
      codeError <= 1'h0;
      wr(`DDRS_SEL_CONTROL, 16'h0008);
    end
  endtask
  task t_unsafe;
    begin
      unsafeCondition <= 1'h1;
      step(3);
      wr(`DDRS_SEL_CONTROL, 16'h0008);
      rdc(`DDRS_SEL_ERROR, 16'h4000);
      unsafeCondition <= 1'h0;
      wr(`DDRS_SEL_CONTROL, 16'h0008);
      rdc(`DDRS_SEL_ERROR, 16'h0000);
    end
  endtask
  task t_attn;
    begin
      powerUp <= 1'h1;
      step(3);
      cmp1(attnA & attnB, 1'h1);
      rdc(`DDRS_SEL_ATTN, 16'h0020);
      cmp({8'h00, av}, 16'h0020);
      wr(`DDRS_SEL_ATTN, 16'h0020);
      step(1);
      cmp({14'h0000, attnA, attnB}, 16'h0001);
      portB <= 1'h1;
      wr(`DDRS_SEL_ATTN, 16'h0020);
      step(1);
      cmp({14'h0000, attnA, attnB}, 16'h0000);
      portB <= 1'h0;
      persistentError <= 1'h1;
      step(3);
      cmp({14'h0000, neutralState, attnA}, 16'h0002);
      driveRequest <= 1'h1;
      step(3);
      cmp1(attnA, 1'h1);
    end
  endtask
  task t_look;
    begin
      wr(`DDRS_SEL_SECTRK, 16'h0000);
      pulseIndex;
      for (i = 0; i < 5; i = i + 1) begin
        @(posedge clk);
        subsectorTick <= 1'h1;
        @(posedge clk);
        subsectorTick <= 1'h0;
      end
      rdc(`DDRS_SEL_ROTPOS, 16'h0005);
      pulseSector;
      rdc(`DDRS_SEL_ROTPOS, 16'h0040);
      cmp1(sectorMatch, 1'h0);
      for (i = 0; i < 21; i = i + 1)
        pulseSector;
      rdc(`DDRS_SEL_ROTPOS, 16'h0000);
      cmp1(sectorMatch, 1'h1);
      pulseSector;
      pulseIndex;
      rdc(`DDRS_SEL_ROTPOS, 16'h0000);
      format18 <= 1'h1;
      for (i = 0; i < 19; i = i + 1)
        pulseSector;
      rdc(`DDRS_SEL_ROTPOS, 16'h04C0);
      pulseSector;
      rdc(`DDRS_SEL_ROTPOS, 16'h0000);
      format18 <= 1'h0;
    end
  endtask
  task t_wrap;
    begin
      wr(`DDRS_SEL_MAINT, 16'h000D);
      wr(`DDRS_SEL_OFFSET, 16'h0003);
      rdc(`DDRS_SEL_OFFSET, 16'h0003);
      rdc(`DDRS_SEL_MAINT, 16'h001D);
      wr(`DDRS_SEL_MAINT, 16'h000F);
      rdc(`DDRS_SEL_OFFSET, 16'h8001);
      rdc(`DDRS_SEL_MAINT, 16'h001F);
      // clock edge with diagnostics off must not shift
      wr(`DDRS_SEL_MAINT, 16'h0008);
      wr(`DDRS_SEL_MAINT, 16'h000A);
      wr(`DDRS_SEL_MAINT, 16'h0001);
      rdc(`DDRS_SEL_OFFSET, 16'h8001);
      wr(`DDRS_SEL_MAINT, 16'h0000);
    end
  endtask
  // ====================
  // main sequence
  initial begin
    {reset, regWrite, regRead, portB, busClear, indexPulse} = 6'h01 << 5;
    {sectorPulse, subsectorTick, activity, format18, unsafeCondition} = 5'h00;
    {powerUp, persistentError, codeError, checkDone} = 4'h0;
    {correctionDone, endOfBlockPulse, wantRun} = 3'h0;
    {otherRequested, driveRequest} = 2'h0;
    regSelect = 5'h00;
    writeData = 16'h0000;
    n_errors  = 0;
    tests_run = 0;
    step(5);
    reset <= 1'h0;
    step(1);
    t_regs;
    t_noprog;
    t_rdchk;
    t_unsafe;
    t_wrap;
    t_look;
    t_attn;
    give_verdict;
  end
endmodule // testbench
